// ---- design/lgd_pkg.sv ----
package lgd_pkg;
  // Clock rate and watchdog timing
  localparam int CLK_MHZ = 25;
  localparam int WDOG_TIME_US = 10000;
  localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;
  // Channel counts for the two width modes
  localparam int CHANNELS = 16;
  localparam int NARROW_CH = 8;
  // Brightness latch value forced while adjust is disabled
  localparam logic [7:0] BRIGHT_FORCE_VAL = 8'h1F;
  // Divide ratio field inside brightness entry 0
  localparam int DIV_LSB = 5;
  localparam int DIV_W = 3;
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] COUNT_OFS = 8'h10;
  localparam logic [1:0] GRAY_WIN = 2'h1;
  localparam logic [1:0] BRIGHT_WIN = 2'h2;
  // Field positions
  localparam int CTRL_LIGHT_OFF_BIT = 0;
  localparam int ST_WDOG_BIT = 0;
  localparam int ST_THERM_BIT = 1;
  localparam int ST_FLAG_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int IRQ_WDOG_BIT = 0;
  localparam int IRQ_THERM_BIT = 1;
  localparam int IRQ_PERIOD_BIT = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic CTRL_RST = 1'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lgd_wb_req_type;

  // Pins from outside the clock domain, synchronised as one group
  typedef struct packed {
    logic shift_clk;
    logic hold;
    logic [7:0] data;
    logic bank;
    logic gate;
    logic width16;
    logic bright_en;
    logic light_off;
    logic gs_clk;
    logic therm_en;
    logic overtemp;
    logic wd_gnd;
    logic scan;
    logic flag;
  } lgd_pins_type;

  typedef enum logic [1:0] {
    DISP_OFF = 2'b00,
    DISP_ARMED = 2'b01,
    DISP_RUN = 2'b10
  } lgd_disp_type;
endpackage : lgd_pkg

// ---- design/lgd_byte_store.sv ----
`timescale 1ns/1ps
module lgd_byte_store #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic clk_in, // System clock
  input wire logic rst_b_in, // Async reset, active low
  input wire logic shift_in, // One-cycle shift strobe
  input wire logic [7:0] data_in, // Byte shifted into entry 0
  input wire logic gate_in, // Latch transparent while high
  input wire logic force_in, // Force every latch entry
  input wire logic [7:0] force_val_in, // Value used while forced
  input wire logic [IDX_W-1:0] rd_idx_in, // Read-back index
  output logic [DEPTH*8-1:0] latch_out, // All latched bytes
  output logic [7:0] rd_data_out // Registered read-back byte
);
  logic [7:0] shift_q [DEPTH];
  logic [7:0] shift_d [DEPTH];
  logic [7:0] latch_q [DEPTH];

  // One shift stage and one latch entry per byte
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      if (i == 0)
      begin : g_head
        assign shift_d[i] = shift_in ? data_in : shift_q[i];
      end
      else
      begin : g_tail
        assign shift_d[i] = shift_in ? shift_q[i-1] : shift_q[i];
      end
      assign latch_out[i*8 +: 8] = latch_q[i];
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          shift_q[i] <= 8'h00;
          latch_q[i] <= 8'h00;
        end
        else
        begin
          shift_q[i] <= shift_d[i];
          // Following the next shift value keeps a byte shifted during the gate
          if (force_in)
            latch_q[i] <= force_val_in;
          else if (gate_in)
            latch_q[i] <= shift_d[i];
          // Gate low: latch keeps its value while shifting goes on
        end
      end
    end
  endgenerate

  // Registered read port for the bus
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rd_data_out <= 8'h00;
    else
      rd_data_out <= latch_q[rd_idx_in];
  end
endmodule : lgd_byte_store

// ---- design/lgd_ctrl_top.sv ----
`timescale 1ns/1ps
module lgd_ctrl_top
  import lgd_pkg::*;
#(
  parameter int WDOG_CYC = lgd_pkg::WDOG_CYCLES
) (
  input wire logic CLK_IN, // 25 MHz system clock
  input wire logic RST_B_IN, // Async reset, active low
  input wire lgd_pkg::lgd_wb_req_type WB_REQ_IN, // Wishbone request
  output logic [31:0] WB_DAT_OUT, // Wishbone read data
  output logic WB_ACK_OUT, // Wishbone acknowledge
  output logic IRQ_OUT, // Level interrupt
  input wire logic SHIFT_CLOCK_IN, // Data shift clock
  input wire logic TRANSFER_HOLD_IN, // High blocks transfer
  input wire logic [7:0] PARALLEL_DATA_IN, // Parallel data byte
  input wire logic BANK_SELECT_IN, // Low grayscale, high brightness
  input wire logic STORE_GATE_IN, // Latch transparent while high
  input wire logic WIDTH_SELECT_IN, // High 16 channels, low 8
  input wire logic BRIGHTNESS_ADJUST_ENABLE_IN, // Low forces 1Fh
  input wire logic LIGHT_OFF_IN, // High turns outputs off
  input wire logic GRAYSCALE_CLOCK_IN, // Grayscale count clock
  output logic GRAYSCALE_CLOCK_REPEAT_OUT, // Delayed grayscale clock
  input wire logic THERMAL_GUARD_ENABLE_IN, // Arms thermal shutdown
  input wire logic OVERTEMP_IN, // Overtemperature indication
  input wire logic WATCHDOG_TIMING_GROUNDED_IN, // High: timing tied low
  input wire logic SCAN_MONITOR_INPUT_IN, // Scan signal monitor
  output logic [15:0] CURRENT_SINK_OUTPUTS_OUT, // High = sinking
  input wire logic SHUTDOWN_FLAG_IN, // Level seen on the flag wire
  output logic SHUTDOWN_FLAG_OUT, // Flag drive value, always low
  output logic SHUTDOWN_FLAG_OE_OUT // High while pulling flag low
);
  localparam int WD_W = $clog2(WDOG_CYC + 1);
  localparam logic [WD_W-1:0] WD_LIM = WD_W'(WDOG_CYC);

  lgd_pins_type pins;
  lgd_pins_type meta_q;
  lgd_pins_type sync_q;
  lgd_pins_type prev_q;
  lgd_disp_type disp_q;
  lgd_disp_type disp_d;
  logic [7:0] count_q;
  logic [DIV_W-1:0] div_q;
  logic [WD_W-1:0] wd_cnt_q;
  logic wd_trip_q;
  logic therm_trip_q;
  logic [15:0] sink_q;
  logic gs_rep_q;
  logic light_off_sw_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic phase_q;
  logic ack_q;
  logic [31:0] dat_q;

  // Gather the pins into one group for the synchroniser
  assign pins = '{shift_clk: SHIFT_CLOCK_IN, hold: TRANSFER_HOLD_IN,
                  data: PARALLEL_DATA_IN, bank: BANK_SELECT_IN,
                  gate: STORE_GATE_IN, width16: WIDTH_SELECT_IN,
                  bright_en: BRIGHTNESS_ADJUST_ENABLE_IN,
                  light_off: LIGHT_OFF_IN, gs_clk: GRAYSCALE_CLOCK_IN,
                  therm_en: THERMAL_GUARD_ENABLE_IN, overtemp: OVERTEMP_IN,
                  wd_gnd: WATCHDOG_TIMING_GROUNDED_IN,
                  scan: SCAN_MONITOR_INPUT_IN, flag: SHUTDOWN_FLAG_IN};

  // Two-stage synchroniser; prev_q only feeds edge detection
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge and strobe decode on synchronised pins
  wire shift_rise = sync_q.shift_clk & ~prev_q.shift_clk;
  wire shift_go = shift_rise & ~sync_q.hold;
  wire gs_rise = sync_q.gs_clk & ~prev_q.gs_clk;
  wire gs_fall = ~sync_q.gs_clk & prev_q.gs_clk;
  wire scan_change = sync_q.scan ^ prev_q.scan;
  wire light_off = sync_q.light_off | light_off_sw_q;

  // Bank select steers shift strobe and gate to one bank
  wire gray_shift = shift_go & ~sync_q.bank;
  wire bright_shift = shift_go & sync_q.bank;
  wire gray_gate = sync_q.gate & ~sync_q.bank;
  wire bright_gate = sync_q.gate & sync_q.bank;
  wire bright_force = ~sync_q.bright_en;

  wire [CHANNELS*8-1:0] gray_lat;
  wire [CHANNELS*8-1:0] bright_lat;
  wire [7:0] gray_rd;
  wire [7:0] bright_rd;

  lgd_byte_store #(.DEPTH(CHANNELS), .IDX_W(4)) u_gray (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .shift_in(gray_shift),
    .data_in(sync_q.data),
    .gate_in(gray_gate),
    .force_in(1'b0),
    .force_val_in(8'h00),
    .rd_idx_in(WB_REQ_IN.adr[5:2]),
    .latch_out(gray_lat),
    .rd_data_out(gray_rd)
  );

  lgd_byte_store #(.DEPTH(CHANNELS), .IDX_W(4)) u_bright (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .shift_in(bright_shift),
    .data_in(sync_q.data),
    .gate_in(bright_gate),
    .force_in(bright_force),
    .force_val_in(BRIGHT_FORCE_VAL),
    .rd_idx_in(WB_REQ_IN.adr[5:2]),
    .latch_out(bright_lat),
    .rd_data_out(bright_rd)
  );

  // Panel brightness: count one of every (ratio+1) falling edges; 1Fh gives 1/1
  wire [DIV_W-1:0] div_ratio = bright_lat[DIV_LSB +: DIV_W];
  wire gs_tick = gs_fall & (div_q == div_ratio);

  // Shutdown sources
  wire shutdown = wd_trip_q | therm_trip_q;

  // Display sequencing: arm after light-off release, run on first counted falling edge (gs_tick)
  always_comb
  begin
    disp_d = disp_q;
    case (disp_q)
      DISP_OFF: if (!light_off) disp_d = DISP_ARMED;
      DISP_ARMED: if (light_off) disp_d = DISP_OFF;
        else if (gs_tick) disp_d = DISP_RUN;
      DISP_RUN: if (light_off) disp_d = DISP_OFF;
      default: disp_d = DISP_OFF;
    endcase
  end

  wire run = (disp_q == DISP_RUN);
  wire period_end = run & gs_tick & (count_q == 8'hFF);

  // Grayscale counter and clock divider
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      disp_q <= DISP_OFF;
      count_q <= 8'h00;
      div_q <= '0;
    end
    else
    begin
      disp_q <= disp_d;
      if (gs_fall)
        div_q <= gs_tick ? '0 : div_q + 1'b1;
      if (!run)
        count_q <= 8'h00;
      else if (gs_tick)
        count_q <= count_q + 8'h01; // Wraps into next period
    end
  end

  // Per-channel compare; 8-channel mode maps the last eight bytes shifted
  genvar k;
  generate
    for (k = 0; k < CHANNELS; k++)
    begin : g_ch
      wire [7:0] v16 = gray_lat[(CHANNELS-1-k)*8 +: 8];
      wire [7:0] v8;
      wire active;
      if (k < NARROW_CH)
      begin : g_lo
        assign v8 = gray_lat[(NARROW_CH-1-k)*8 +: 8];
        assign active = 1'b1;
      end
      else
      begin : g_hi
        assign v8 = 8'h00;
        assign active = sync_q.width16;
      end
      wire [7:0] val = sync_q.width16 ? v16 : v8;
      wire on = run & active & ~light_off & ~shutdown & (count_q < val);
      always_ff @(posedge CLK_IN or negedge RST_B_IN)
      begin
        if (!RST_B_IN)
          sink_q[k] <= 1'b0;
        else
          sink_q[k] <= on;
      end
    end
  endgenerate

  // Watchdog: restart on each scan level change; recover on the next change
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      wd_cnt_q <= '0;
      wd_trip_q <= 1'b0;
    end
    else if (sync_q.wd_gnd)
    begin
      wd_cnt_q <= '0;
      wd_trip_q <= 1'b0;
    end
    else if (scan_change)
    begin
      wd_cnt_q <= '0;
      wd_trip_q <= 1'b0;
    end
    else if (wd_cnt_q == WD_LIM)
      wd_trip_q <= 1'b1;
    else
      wd_cnt_q <= wd_cnt_q + 1'b1;
  end

  // Thermal trip holds until guard enable goes low, so a hot part cannot flicker back on
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      therm_trip_q <= 1'b0;
    else
      therm_trip_q <= sync_q.therm_en & (therm_trip_q | sync_q.overtemp);
  end

  // Cascade copy of grayscale clock, delayed by the synchroniser
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      gs_rep_q <= 1'b0;
    else
      gs_rep_q <= sync_q.gs_clk;
  end

  // Bus decode; access taken in the second cycle of the request
  wire req = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~ack_q;
  wire take = req & phase_q;
  wire wr0 = take & WB_REQ_IN.we & WB_REQ_IN.sel[0];
  wire [7:0] adr = WB_REQ_IN.adr;
  wire [IRQ_W-1:0] wdat = WB_REQ_IN.dat[IRQ_W-1:0];
  wire wr_ctrl = wr0 & (adr == CTRL_OFS);
  wire wr_stat = wr0 & (adr == IRQ_STAT_OFS);
  wire wr_mask = wr0 & (adr == IRQ_MASK_OFS);
  wire [IRQ_W-1:0] events;
  assign events[IRQ_WDOG_BIT] = wd_cnt_q == WD_LIM & ~wd_trip_q & ~sync_q.wd_gnd & ~scan_change;
  assign events[IRQ_THERM_BIT] = sync_q.therm_en & sync_q.overtemp & ~therm_trip_q;
  assign events[IRQ_PERIOD_BIT] = period_end;
  wire [IRQ_W-1:0] clr = wr_stat ? wdat : '0;

  // Read mux; unmapped addresses read zero
  wire [31:0] status = {28'h0000000, run, ~sync_q.flag, therm_trip_q, wd_trip_q};
  wire [31:0] rd_mux =
    (adr == CTRL_OFS) ? {31'h00000000, light_off_sw_q} :
    (adr == STATUS_OFS) ? status :
    (adr == IRQ_STAT_OFS) ? {29'h00000000, irq_stat_q} :
    (adr == IRQ_MASK_OFS) ? {29'h00000000, irq_mask_q} :
    (adr == COUNT_OFS) ? {24'h000000, count_q} :
    (adr[7:6] == GRAY_WIN) ? {24'h000000, gray_rd} :
    (adr[7:6] == BRIGHT_WIN) ? {24'h000000, bright_rd} : 32'h00000000;

  // Bus slave, control and interrupt registers; set wins over clear
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      phase_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      light_off_sw_q <= CTRL_RST;
      irq_stat_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
    end
    else
    begin
      phase_q <= req & ~phase_q;
      ack_q <= take;
      if (take & ~WB_REQ_IN.we)
        dat_q <= rd_mux;
      if (wr_ctrl)
        light_off_sw_q <= WB_REQ_IN.dat[CTRL_LIGHT_OFF_BIT];
      if (wr_mask)
        irq_mask_q <= wdat;
      irq_stat_q <= (irq_stat_q & ~clr) | events;
    end
  end

  // Outputs; the flag pin only ever pulls low
  assign WB_DAT_OUT = dat_q;
  assign WB_ACK_OUT = ack_q;
  assign IRQ_OUT = |(irq_stat_q & irq_mask_q);
  assign CURRENT_SINK_OUTPUTS_OUT = sink_q;
  assign GRAYSCALE_CLOCK_REPEAT_OUT = gs_rep_q;
  assign SHUTDOWN_FLAG_OUT = 1'b0;
  assign SHUTDOWN_FLAG_OE_OUT = shutdown;
endmodule : lgd_ctrl_top

// ---- verif/lgd_ctrl_checker.sv ----
`timescale 1ns/1ps
module lgd_ctrl_checker
  import lgd_pkg::*;
#(
  parameter int WDOG_CYC = 200
) (
  input wire logic CLK_IN, // Clock
  input wire logic RST_B_IN, // Reset
  input wire lgd_pkg::lgd_wb_req_type WB_REQ_IN, // Bus request
  input wire logic WB_ACK_OUT, // Bus ack
  input wire logic IRQ_OUT, // Interrupt
  input wire logic GRAYSCALE_CLOCK_IN, // Count clock
  input wire logic GRAYSCALE_CLOCK_REPEAT_OUT, // Forwarded clock
  input wire logic LIGHT_OFF_IN, // Light-off
  input wire logic WIDTH_SELECT_IN, // Width
  input wire logic THERMAL_GUARD_ENABLE_IN, // Thermal arm
  input wire logic OVERTEMP_IN, // Overtemperature
  input wire logic WATCHDOG_TIMING_GROUNDED_IN, // Watchdog off
  input wire logic SCAN_MONITOR_INPUT_IN, // Scan line
  input wire logic [15:0] CURRENT_SINK_OUTPUTS_OUT, // Sinks
  input wire logic SHUTDOWN_FLAG_OE_OUT // Flag pull-down
);
  logic scan_q;
  int unsigned idle_q;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  // Cycles since the scan line last moved; sync lag is covered by slack
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN) idle_q <= 0;
    else idle_q <= (scan_q != SCAN_MONITOR_INPUT_IN) ? 0 : idle_q + 1;
  end
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN) scan_q <= 1'h0;
    else scan_q <= SCAN_MONITOR_INPUT_IN;
  end
  ack_time_a: assert property ($rose(WB_REQ_IN.stb) |-> ##[1:2] WB_ACK_OUT)
    else $error("bus ack late");
  ack_pulse_a: assert property (WB_ACK_OUT |-> WB_REQ_IN.cyc ##1 !WB_ACK_OUT)
    else $error("bus ack not a single pulse");
  clock_repeat_a: assert property ($rose(GRAYSCALE_CLOCK_IN) |-> ##[2:4] $rose(GRAYSCALE_CLOCK_REPEAT_OUT))
    else $error("forwarded clock missing");
  light_off_a: assert property (LIGHT_OFF_IN [*5] |-> CURRENT_SINK_OUTPUTS_OUT == 16'h0)
    else $error("sinks on during light-off");
  narrow_mode_a: assert property ((!WIDTH_SELECT_IN) [*5] |-> CURRENT_SINK_OUTPUTS_OUT[15:8] == 8'h0)
    else $error("upper sinks on in narrow mode");
  shutdown_dark_a: assert property (SHUTDOWN_FLAG_OE_OUT [*2] |-> CURRENT_SINK_OUTPUTS_OUT == 16'h0)
    else $error("sinks on while shut down");
  thermal_trip_a: assert property ((THERMAL_GUARD_ENABLE_IN && OVERTEMP_IN) [*6] |-> SHUTDOWN_FLAG_OE_OUT)
    else $error("thermal trip missing");
  guards_off_a: assert property ((!THERMAL_GUARD_ENABLE_IN && WATCHDOG_TIMING_GROUNDED_IN) [*6] |-> !SHUTDOWN_FLAG_OE_OUT)
    else $error("shutdown with both guards disabled");
  wdog_trip_a: assert property (idle_q == WDOG_CYC + 8 && !WATCHDOG_TIMING_GROUNDED_IN |-> SHUTDOWN_FLAG_OE_OUT)
    else $error("watchdog trip missing");
  cover property (WB_ACK_OUT && WB_REQ_IN.we);
  cover property (SHUTDOWN_FLAG_OE_OUT);
  cover property (IRQ_OUT);
endmodule : lgd_ctrl_checker
bind lgd_ctrl_top lgd_ctrl_checker #(.WDOG_CYC(WDOG_CYC)) chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
  .WB_REQ_IN(WB_REQ_IN), .WB_ACK_OUT(WB_ACK_OUT), .IRQ_OUT(IRQ_OUT), .LIGHT_OFF_IN(LIGHT_OFF_IN),
  .GRAYSCALE_CLOCK_IN(GRAYSCALE_CLOCK_IN), .GRAYSCALE_CLOCK_REPEAT_OUT(GRAYSCALE_CLOCK_REPEAT_OUT),
  .WIDTH_SELECT_IN(WIDTH_SELECT_IN), .THERMAL_GUARD_ENABLE_IN(THERMAL_GUARD_ENABLE_IN),
  .OVERTEMP_IN(OVERTEMP_IN), .WATCHDOG_TIMING_GROUNDED_IN(WATCHDOG_TIMING_GROUNDED_IN),
  .SCAN_MONITOR_INPUT_IN(SCAN_MONITOR_INPUT_IN), .SHUTDOWN_FLAG_OE_OUT(SHUTDOWN_FLAG_OE_OUT),
  .CURRENT_SINK_OUTPUTS_OUT(CURRENT_SINK_OUTPUTS_OUT));

// ---- verif/lgd_panel_model.sv ----
`timescale 1ns/1ps
module lgd_panel_model (
  input wire logic clk_in, // Pacing clock
  input wire logic scan_run_in, // Keep scan toggling
  output logic shift_clk_out, // Shift clock, still between bytes
  output logic hold_out, // Transfer hold
  output logic [7:0] data_out, // Parallel byte
  output logic scan_out // Scan line
);
  logic [3:0] div_q;
  initial
  begin
    shift_clk_out = 1'h0;
    hold_out = 1'h1;
    data_out = 8'h0;
    scan_out = 1'h0;
    div_q = 4'h0;
  end
  // Scan toggles every 16 cycles while scan_run_in is high
  always @(posedge clk_in)
  begin
    div_q <= div_q + 4'h1;
    if (scan_run_in && div_q == 4'hF) scan_out <= ~scan_out;
  end
  // One byte per 320 ns shift clock; data inverted once hold time ends
  task automatic send(input logic [7:0] b, input logic hb);
    @(posedge clk_in);
    hold_out <= hb;
    data_out <= b;
    // Three cycles of setup keep back-to-back bytes on an eight-cycle period
    repeat (3) @(posedge clk_in);
    shift_clk_out <= 1'h1;
    repeat (4) @(posedge clk_in);
    shift_clk_out <= 1'h0;
    hold_out <= 1'h1;
    data_out <= ~b;
  endtask : send
endmodule : lgd_panel_model

// ---- verif/test_led_grayscale_driver_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_led_grayscale_driver_ctrl;
  import lgd_pkg::*;
  localparam int WD = 200;
  logic clk = 1'h0, rst_b = 1'h0, bank = 1'h0, gate = 1'h0, wide = 1'h0, bri = 1'h0;
  logic loff = 1'h0, gs = 1'h0, therm = 1'h0, hot = 1'h0, gnd = 1'h0, scan_run = 1'h1;
  logic ack, irq, rep, oe, fo, sclk, hold, scan;
  logic [7:0] din;
  logic [15:0] sink;
  logic [31:0] rdat, d;
  lgd_wb_req_type wb = '0;
  int bad_count = 0, checked = 0;
  // Pull-up on the open-drain flag wire
  wire flag = oe ? fo : 1'h1;
  always #20 clk = ~clk;
  lgd_ctrl_top #(.WDOG_CYC(WD)) uut (.CLK_IN(clk), .RST_B_IN(rst_b), .WB_REQ_IN(wb),
    .WB_DAT_OUT(d), .WB_ACK_OUT(ack), .IRQ_OUT(irq), .SHIFT_CLOCK_IN(sclk),
    .TRANSFER_HOLD_IN(hold), .PARALLEL_DATA_IN(din), .BANK_SELECT_IN(bank),
    .STORE_GATE_IN(gate), .WIDTH_SELECT_IN(wide), .BRIGHTNESS_ADJUST_ENABLE_IN(bri),
    .LIGHT_OFF_IN(loff), .GRAYSCALE_CLOCK_IN(gs), .GRAYSCALE_CLOCK_REPEAT_OUT(rep),
    .THERMAL_GUARD_ENABLE_IN(therm), .OVERTEMP_IN(hot), .WATCHDOG_TIMING_GROUNDED_IN(gnd),
    .SCAN_MONITOR_INPUT_IN(scan), .CURRENT_SINK_OUTPUTS_OUT(sink), .SHUTDOWN_FLAG_IN(flag),
    .SHUTDOWN_FLAG_OUT(fo), .SHUTDOWN_FLAG_OE_OUT(oe));
  lgd_panel_model pm (.clk_in(clk), .scan_run_in(scan_run), .shift_clk_out(sclk),
    .hold_out(hold), .data_out(din), .scan_out(scan));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb_go(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge clk);
    wb <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: 4'hF, dat: v};
    @(posedge clk iff ack);
    rdat = d;
    wb <= '0;
    @(posedge clk);
  endtask : wb_go
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    wb_go(a, 1'h0, 32'h0);
    `CHK(n, e, rdat)
  endtask : rd_chk
  task automatic gs_pulse;
    gs <= 1'h1;
    tick(4);
    gs <= 1'h0;
    tick(6);
  endtask : gs_pulse
  task automatic t_regs;
    rd_chk("ctrl", CTRL_OFS, 32'h0);
    wb_go(CTRL_OFS, 1'h1, 32'h1);
    rd_chk("ctrl set", CTRL_OFS, 32'h1);
    wb_go(CTRL_OFS, 1'h1, 32'h0);
    wb_go(8'h24, 1'h1, 32'hFF);
    rd_chk("unmapped", 8'h24, 32'h0);
    wb_go(IRQ_MASK_OFS, 1'h1, 32'h5);
    rd_chk("mask", IRQ_MASK_OFS, 32'h5);
    wb_go(IRQ_MASK_OFS, 1'h1, 32'h0);
  endtask : t_regs
  task automatic t_latch;
    for (int i = 1; i < 16; i++) pm.send(8'(i), 1'h0);
    rd_chk("gray0 held", 8'h40, 32'h0);
    gate <= 1'h1;
    pm.send(8'h10, 1'h0);
    tick(4);
    rd_chk("gray0 open", 8'h40, 32'h10);
    rd_chk("gray15 open", 8'h7C, 32'h1);
    pm.send(8'h55, 1'h1);
    rd_chk("gray0 hold", 8'h40, 32'h10);
    gate <= 1'h0;
    pm.send(8'hEE, 1'h0);
    rd_chk("gray0 closed", 8'h40, 32'h10);
    bank <= 1'h1;
    bri <= 1'h1;
    tick(4);
    gate <= 1'h1;
    pm.send(8'h05, 1'h0);
    tick(4);
    rd_chk("bright0", 8'h80, 32'h5);
    rd_chk("gray0 kept", 8'h40, 32'h10);
    gate <= 1'h0;
    bri <= 1'h0;
    bank <= 1'h0;
    tick(4);
    rd_chk("bright forced", 8'h80, 32'h1F);
  endtask : t_latch
  // Wide mode: channel k holds k+1; narrow mode maps channel k to entry 7-k, which holds k+9
  task automatic t_pwm(input logic w);
    logic [15:0] e;
    wide <= w;
    loff <= 1'h1;
    tick(8);
    loff <= 1'h0;
    tick(4);
    // One count edge lights the panel, so light-off has something to turn off
    gs_pulse();
    loff <= 1'h1;
    tick(8);
    `CHK("sinks off", 16'h0, sink)
    loff <= 1'h0;
    tick(4);
    for (int m = 1; m < 18; m++)
    begin
      gs_pulse();
      for (int k = 0; k < 16; k++) e[k] = (w || k < 8) && ((w ? k + 1 : k + 9) > m - 1);
      `CHK("sinks", e, sink)
    end
    // First edge starts at zero, the sixteen after it count up
    rd_chk("count", COUNT_OFS, 32'h10);
  endtask : t_pwm
  task automatic t_wdog;
    scan_run <= 1'h0;
    tick(WD + 20);
    `CHK("wd oe", 1'h1, oe)
    `CHK("wd sinks", 16'h0, sink)
    wb_go(STATUS_OFS, 1'h0, 32'h0);
    `CHK("status", 3'h5, rdat[2:0])
    `CHK("irq masked", 1'h0, irq)
    wb_go(IRQ_MASK_OFS, 1'h1, 32'h1);
    `CHK("irq raised", 1'h1, irq)
    wb_go(IRQ_STAT_OFS, 1'h1, 32'h1);
    `CHK("irq cleared", 1'h0, irq)
    scan_run <= 1'h1;
    tick(40);
    `CHK("wd recover", 1'h0, oe)
    gnd <= 1'h1;
    scan_run <= 1'h0;
    tick(WD + 20);
    `CHK("wd grounded", 1'h0, oe)
    scan_run <= 1'h1;
    tick(40);
    gnd <= 1'h0;
  endtask : t_wdog
  task automatic t_therm;
    hot <= 1'h1;
    tick(10);
    `CHK("tsd unarmed", 1'h0, oe)
    therm <= 1'h1;
    tick(10);
    `CHK("tsd oe", 1'h1, oe)
    `CHK("tsd sinks", 16'h0, sink)
    therm <= 1'h0;
    tick(10);
    `CHK("tsd recover", 1'h0, oe)
  endtask : t_therm
  task automatic end_sim;
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    tick(6);
    rst_b <= 1'h1;
    t_regs();
    t_latch();
    t_pwm(1'h1);
    t_pwm(1'h0);
    t_wdog();
    t_therm();
    end_sim();
  end
  // Run needs under 1500 cycles; cut a hang well beyond that
  initial
  begin
    #(20000 * 40);
    bad_count++;
    end_sim();
  end
endmodule : test_led_grayscale_driver_ctrl
